// *** inc/gpio_port_pkg.sv ***
// types of the six-bit general-purpose port
package gpio_port_pkg;
  typedef enum logic [2:0] {
    OSC_EXTERNAL_CLOCK = 3'b000,
    OSC_LOW_POWER_CRYSTAL = 3'b001,
    OSC_MEDIUM_GAIN_CRYSTAL = 3'b010,
    OSC_HIGH_GAIN_CRYSTAL = 3'b011,
    OSC_OTHER = 3'b100
  } osc_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;

  typedef struct packed {
    bus_state_t state;
    logic [5:0] latch;
    logic [5:0] direction;
    logic [7:0] analog_sel;
    logic [7:0] config_bits;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [31:0] rdata;
  } port_state_t;
endpackage

// *** inc/gpio_port_regs.svh ***
// register offsets, field positions and reset values
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

`define OFS_PIN_LEVEL_DATA 4'h0
`define OFS_PIN_DIRECTION_CONTROL 4'h4
`define OFS_ANALOG_SELECT_BITS 4'h8
`define OFS_PORT_CONFIG 4'hc

`define RST_DIRECTION_BITS 6'h3f
`define RST_LATCH_BITS 6'h00
`define RST_ANALOG_SELECT_BITS 8'hff
`define RST_PORT_CONFIG 8'h00

`define PIN_INPUT_ONLY 3
`define PIN_OSC_IN 5
`define PIN_OSC_OUT 4
`define CFG_RESET_PIN_EN_BIT 0
`define CFG_OSC_MODE_LSB 1
`define CFG_OSC_MODE_MSB 3

`endif

// *** rtl/gpio_port.sv ***
// six-bit bidirectional port with Avalon-MM register slave
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "gpio_port_regs.svh"

module gpio_port #(
  parameter int PIN_COUNT = 6
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  // avalon-mm slave
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // pins, three signals each
  input wire logic [PIN_COUNT-1:0] I_PIN,
  output logic [PIN_COUNT-1:0] O_PIN,
  output logic [PIN_COUNT-1:0] O_PIN_OE_N,
  // shared peripherals claiming pins
  input wire logic [PIN_COUNT-1:0] I_PERIPH_EN,
  // analog inputs gate change detection
  output logic [PIN_COUNT-1:0] O_CHANGE_DETECT_EN,
  output logic [PIN_COUNT-1:0] O_DIGITAL_INPUT_EN
);
  import gpio_port_pkg::*;

  port_state_t s_reg;
  port_state_t s_next;

  logic crystal_mode;
  logic reset_pin_en;
  logic [5:0] dir_view;
  logic [5:0] pin_view;
  logic [31:0] read_word;
  logic req;

  ////////////////////////////////////////////////////////////////////////
  // decoding: crystal mode feeds read path and pin drivers, reset-pin bit only the read path, req the bus
  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == OSC_LOW_POWER_CRYSTAL) ||
                 (mode == OSC_MEDIUM_GAIN_CRYSTAL) ||
                 (mode == OSC_HIGH_GAIN_CRYSTAL);
  endfunction

  assign crystal_mode = is_crystal(
    s_reg.config_bits[`CFG_OSC_MODE_MSB:`CFG_OSC_MODE_LSB]);
  assign reset_pin_en = s_reg.config_bits[`CFG_RESET_PIN_EN_BIT];
  assign req = I_AVS_READ | I_AVS_WRITE;

  ////////////////////////////////////////////////////////////////////////
  // per-pin views of direction and sampled level
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      logic taken;
      // crystal pins and pin 3 are inputs whatever is stored
      assign taken = (g == `PIN_INPUT_ONLY) ||
        (crystal_mode && (g == `PIN_OSC_IN || g == `PIN_OSC_OUT));
      assign dir_view[g] = taken | s_reg.direction[g];
      // analog select zeroes the digital read, pin 3 masked as reset
      assign pin_view[g] = s_reg.sync2[g] & ~s_reg.analog_sel[g] &
        ~((g == `PIN_INPUT_ONLY) && reset_pin_en);
      // driver follows direction and peripheral enable; analog select ignored
      assign O_PIN_OE_N[g] = dir_view[g] | I_PERIPH_EN[g];
      assign O_PIN[g] = s_reg.latch[g];
      // analog pins lose input buffer and change detection
      assign O_DIGITAL_INPUT_EN[g] = ~s_reg.analog_sel[g];
      assign O_CHANGE_DETECT_EN[g] = ~s_reg.analog_sel[g] &
        ~I_PERIPH_EN[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read mux; upper bits read as zero
  always_comb begin
    read_word = 32'h0000_0000;
    if (I_AVS_ADDRESS == `OFS_PIN_LEVEL_DATA) begin
      read_word[5:0] = pin_view;
    end else if (I_AVS_ADDRESS == `OFS_PIN_DIRECTION_CONTROL) begin
      read_word[5:0] = dir_view;
    end else if (I_AVS_ADDRESS == `OFS_ANALOG_SELECT_BITS) begin
      read_word[7:0] = s_reg.analog_sel;
    end else if (I_AVS_ADDRESS == `OFS_PORT_CONFIG) begin
      read_word[7:0] = s_reg.config_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state: one-wait-state slave, writes land in the answer cycle
  always_comb begin
    s_next = s_reg;
    s_next.sync1 = I_PIN;
    s_next.sync2 = s_reg.sync1;
    case (s_reg.state)
      BUS_IDLE: begin
        if (req) begin
          s_next.state = BUS_ANSWER;
          s_next.rdata = read_word;
        end
      end
      BUS_ANSWER: begin
        s_next.state = BUS_IDLE;
        if (I_AVS_WRITE && I_AVS_BYTEENABLE[0]) begin
          if (I_AVS_ADDRESS == `OFS_PIN_LEVEL_DATA) begin
            // pin_view copy is overwritten, so the latch takes the written data as is
            s_next.latch = pin_view;
            s_next.latch = I_AVS_WRITEDATA[5:0];
          end else if (I_AVS_ADDRESS == `OFS_PIN_DIRECTION_CONTROL) begin
            s_next.direction = I_AVS_WRITEDATA[5:0];
            s_next.direction[`PIN_INPUT_ONLY] = 1'b1;
          end else if (I_AVS_ADDRESS == `OFS_ANALOG_SELECT_BITS) begin
            s_next.analog_sel = I_AVS_WRITEDATA[7:0];
          end else if (I_AVS_ADDRESS == `OFS_PORT_CONFIG) begin
            s_next.config_bits = I_AVS_WRITEDATA[7:0];
          end
        end
      end
      default: begin
        s_next.state = BUS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      s_reg.state <= BUS_IDLE;
      s_reg.latch <= `RST_LATCH_BITS;
      s_reg.direction <= `RST_DIRECTION_BITS;
      s_reg.analog_sel <= `RST_ANALOG_SELECT_BITS;
      s_reg.config_bits <= `RST_PORT_CONFIG;
      s_reg.sync1 <= 6'h00;
      s_reg.sync2 <= 6'h00;
      s_reg.rdata <= 32'h0000_0000;
    end else begin
      s_reg <= s_next;
    end
  end

  // waitrequest low in the answer cycle and whenever no request is present
  assign O_AVS_WAITREQUEST = req && (s_reg.state != BUS_ANSWER);
  assign O_AVS_READDATA = s_reg.rdata;
endmodule

// *** verification/gpio_pins_model.sv ***
// external circuitry on the six pins
`timescale 1ns/1ps
module gpio_pins_model (
  // from the port and the outside world
  input wire logic [5:0] i_out,
  input wire logic [5:0] i_oe_n,
  input wire logic [5:0] i_ext,
  // resolved pin levels
  output logic [5:0] o_pin
);
  // port driver wins where enabled, else outside level
  assign o_pin = (i_oe_n & i_ext) | (~i_oe_n & i_out);
endmodule

// *** verification/gpio_port_assertions.sv ***
// checker: port properties of the six-bit port
`timescale 1ns/1ps
module gpio_port_assertions #(parameter int PIN_COUNT = 6) (
  // clock, reset, bus
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  // pins
  input wire logic [PIN_COUNT-1:0] O_PIN,
  input wire logic [PIN_COUNT-1:0] O_PIN_OE_N,
  input wire logic [PIN_COUNT-1:0] O_CHANGE_DETECT_EN,
  input wire logic [PIN_COUNT-1:0] O_DIGITAL_INPUT_EN
);
  logic done;
  logic rd;
  ////////////////////////////////
  // one domain, so one default for all
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);
  // an access ends in the cycle waitrequest drops
  assign done = (I_AVS_READ || I_AVS_WRITE) && !O_AVS_WAITREQUEST;
  assign rd = done && I_AVS_READ;
  AST_ONE_WAIT: assert property (
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("wait");
  AST_RESET: assert property (
    $fell(I_SRST) |-> O_PIN_OE_N == '1 && O_PIN == '0) else $error("reset");
  AST_WRITE: assert property (
    done && I_AVS_WRITE && I_AVS_ADDRESS == 4'h0 && I_AVS_BYTEENABLE[0]
    |=> O_PIN == $past(I_AVS_WRITEDATA[5:0])) else $error("latch");
  // only the data and direction registers have bits 7 and 6 unimplemented
  AST_HIGH: assert property (
    rd && (I_AVS_ADDRESS == 4'h0 || I_AVS_ADDRESS == 4'h4)
    |-> O_AVS_READDATA[31:6] == '0) else $error("high");
  AST_DIR3: assert property (
    rd && I_AVS_ADDRESS == 4'h4 |-> O_AVS_READDATA[3]) else $error("dir3");
  AST_ANALOG: assert property (
    rd && I_AVS_ADDRESS == 4'h0
    |-> (O_AVS_READDATA[5:0] & ~O_DIGITAL_INPUT_EN) == '0) else $error("ana");
  AST_PIN3: assert property (O_PIN_OE_N[3]) else $error("pin3");
  AST_QUIET: assert property (
    (O_CHANGE_DETECT_EN & ~O_DIGITAL_INPUT_EN) == '0) else $error("change");
endmodule
bind gpio_port gpio_port_assertions #(.PIN_COUNT(PIN_COUNT)) chk_inst (
  .I_CLK_SYS, .I_SRST, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE,
  .I_AVS_WRITEDATA, .I_AVS_BYTEENABLE, .O_AVS_READDATA, .O_AVS_WAITREQUEST,
  .O_PIN, .O_PIN_OE_N, .O_CHANGE_DETECT_EN, .O_DIGITAL_INPUT_EN);

// *** verification/tb_gpio_port.sv ***
// bench: register accesses against pin levels
`timescale 1ns/1ps
module tb_gpio_port;
  logic I_CLK_SYS = 0, I_SRST = 1, I_AVS_READ = 0, I_AVS_WRITE = 0;
  logic [3:0] I_AVS_ADDRESS = '0, I_AVS_BYTEENABLE = 4'hf;
  logic [31:0] I_AVS_WRITEDATA = '0, O_AVS_READDATA;
  logic O_AVS_WAITREQUEST;
  logic [5:0] I_PIN, O_PIN, O_PIN_OE_N, O_CHANGE_DETECT_EN, O_DIGITAL_INPUT_EN;
  logic [5:0] I_PERIPH_EN = '0, ext = 6'h2a;
  int bad_count = 0, num_checks = 0;
  gpio_port gpio_port_inst (.I_CLK_SYS, .I_SRST, .I_AVS_ADDRESS, .I_AVS_READ,
    .I_AVS_WRITE, .I_AVS_WRITEDATA, .I_AVS_BYTEENABLE, .O_AVS_READDATA,
    .O_AVS_WAITREQUEST, .I_PIN, .O_PIN, .O_PIN_OE_N, .I_PERIPH_EN,
    .O_CHANGE_DETECT_EN, .O_DIGITAL_INPUT_EN);
  gpio_pins_model gpio_pins_model_inst (.i_out(O_PIN), .i_oe_n(O_PIN_OE_N),
    .i_ext(ext), .o_pin(I_PIN));
  ////////////////////////////////
  // 50 mhz clock
  initial begin
    forever #10 I_CLK_SYS = ~I_CLK_SYS;
  end
  // compare at the falling edge, once edge updates landed
  task chk(input logic [31:0] g, e);
    @(negedge I_CLK_SYS);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // gap of three edges lets pins cross the synchroniser
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d, e);
    repeat (3) @(posedge I_CLK_SYS);
    I_AVS_READ <= !w;
    I_AVS_WRITE <= w;
    I_AVS_ADDRESS <= a;
    I_AVS_WRITEDATA <= d;
    do @(posedge I_CLK_SYS); while (O_AVS_WAITREQUEST !== 1'b0);
    I_AVS_READ <= 0;
    I_AVS_WRITE <= 0;
    // read data compared at the falling edge after the answer edge; writes settle before any look
    if (!w) chk(O_AVS_READDATA, e);
    else @(negedge I_CLK_SYS);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog, far beyond the fewer than two hundred cycles needed
  initial begin
    #100000;
    bad_count++;
    end_of_test;
  end
  ////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge I_CLK_SYS);
    I_SRST <= 0;
    acc(0, 4'h4, 0, 32'h3f);
    acc(0, 4'h8, 0, 32'hff);
    acc(1, 4'h8, 0, 0);
    acc(0, 4'h0, 0, 32'h2a);
    acc(1, 4'hc, 1, 0);
    acc(0, 4'h0, 0, 32'h22);
    acc(1, 4'hc, 0, 0);
    acc(1, 4'h4, 0, 0);
    acc(0, 4'h4, 0, 32'h08);
    acc(1, 4'h0, 32'hffff_ff35, 0);
    chk(O_PIN, 6'h35);
    acc(0, 4'h0, 0, 32'h3d);
    // drive pins 0 and 2 while analog: the documented hazard
    acc(1, 4'h8, 5, 0);
    chk(O_DIGITAL_INPUT_EN, 6'h3a);
    chk(O_PIN, 6'h35);
    acc(0, 4'h0, 0, 32'h38);
    acc(1, 4'h0, 32'h38, 0);
    chk(O_PIN, 6'h38);
    @(posedge I_CLK_SYS);
    I_PERIPH_EN <= 6'h02;
    @(negedge I_CLK_SYS);
    chk(O_PIN_OE_N, 6'h0a);
    chk(O_CHANGE_DETECT_EN, 6'h38);
    @(posedge I_CLK_SYS);
    I_PERIPH_EN <= '0;
    for (int m = 1; m < 4; m++) begin
      acc(1, 4'hc, m << 1, 0);
      acc(0, 4'h4, 0, 32'h38);
      chk(O_PIN_OE_N, 6'h38);
    end
    acc(1, 4'hc, 0, 0);
    acc(0, 4'h4, 0, 32'h08);
    @(posedge I_CLK_SYS);
    I_AVS_BYTEENABLE <= 4'h0;
    acc(1, 4'h0, 32'h3f, 0);
    chk(O_PIN, 6'h38);
    @(posedge I_CLK_SYS);
    I_AVS_BYTEENABLE <= 4'hf;
    acc(1, 4'h2, 32'h3f, 0);
    acc(0, 4'h2, 0, 0);
    chk(O_PIN, 6'h38);
    // software puts the analog pins back to input before using them
    acc(1, 4'h4, 32'h05, 0);
    chk(O_PIN_OE_N, 6'h0d);
    end_of_test;
  end
endmodule
